// ---- logic/lsg_light_sensor.sv ----
// light sensor configuration registers, measurement sequencing and threshold flags
// How it works
// - bit 6 of the second configuration register picks full (0) or half (1) photodiode area.
// - bits 4:3 of the second configuration register pick gain x1, x2, x0.66 or x0.5 for codes 00 to 11.
// - one diode-area and gain setting drives the ambient and infrared channels together.
// - in selftimed mode measurements run back to back until the sensor is switched off.
// - in active force mode each software trigger starts exactly one measurement.
// - the sensor comes out of reset in selftimed mode.
// - only the ambient result is compared against the thresholds, never the infrared one.
// - bit 1 of the first configuration register enables the threshold function and resets to off.
// - bits 2:1 of the second configuration register ask for 1, 2, 4 or 8 consecutive outside results.
// - the high threshold is a writable low byte at 0x04 and high byte at 0x05.
// - the low threshold is a writable low byte at 0x06 and high byte at 0x07, set on its own.
// - low and high crossing flags sit at bits 2 and 1 of 0x17 and reading 0x17 clears them.
// - a cleared flag is not raised again until the result has first come back inside the window.
`timescale 1ns/1ps
module lsg_light_sensor (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic meas_start_o,
    input wire logic meas_done_i,
    input wire logic [15:0] als_result_i,
    output logic sensor_on_o,
    output logic [2:0] integration_period_select_o,
    output logic [1:0] light_gain_select_o,
    output logic diode_area_select_o,
    output logic alert_n_o
);

    logic [7:0] light_config_first_reg;
    logic [7:0] light_config_second_reg;
    logic [7:0] upper_limit_low_byte_reg;
    logic [7:0] upper_limit_high_byte_reg;
    logic [7:0] lower_limit_low_byte_reg;
    logic [7:0] lower_limit_high_byte_reg;
    logic upper_crossing_flag_reg;
    logic lower_crossing_flag_reg;
    logic force_done_flag_reg;
    lsg_pkg::lsg_seq_state_type state_reg;
    logic sensor_on;
    logic force_mode;
    logic trigger_pending;
    logic threshold_irq_enable;
    logic go;
    logic meas_valid;
    logic status_read;
    logic raise_upper;
    logic raise_lower;
    logic [7:0] read_mux;

    assign sensor_on = ~light_config_first_reg[lsg_pkg::SHUT_FIRST_BIT]
                     & ~light_config_second_reg[lsg_pkg::SHUT_SECOND_BIT];
    assign force_mode = light_config_first_reg[lsg_pkg::FORCE_MODE_BIT];
    assign trigger_pending = light_config_first_reg[lsg_pkg::TRIGGER_BIT];
    // enable bit of the threshold function
    assign threshold_irq_enable = light_config_first_reg[lsg_pkg::IRQ_EN_BIT];
    assign status_read = reg_rd_i && (reg_addr_i == lsg_pkg::STATUS_ADDR);
    assign meas_valid = (state_reg == lsg_pkg::SEQ_BUSY) && meas_done_i;
    // selftimed restarts freely, force mode waits for a trigger
    assign go = sensor_on && (!force_mode || trigger_pending);

    // first configuration; trigger self-clears when its measurement ends
    // reset value leaves force mode off, i.e. selftimed
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            light_config_first_reg <= lsg_pkg::CONF_FIRST_RESET;
        else if (reg_wr_i && reg_addr_i == lsg_pkg::CONF_FIRST_ADDR)
            light_config_first_reg <= reg_wdata_i;
        else if (meas_valid && force_mode)
            light_config_first_reg[lsg_pkg::TRIGGER_BIT] <= 1'b0;
    end

    // second configuration: persistence, gain, diode area, shutdown
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            light_config_second_reg <= lsg_pkg::CONF_SECOND_RESET;
        else if (reg_wr_i && reg_addr_i == lsg_pkg::CONF_SECOND_ADDR)
            light_config_second_reg <= reg_wdata_i;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            upper_limit_low_byte_reg <= lsg_pkg::LIMIT_RESET;
            upper_limit_high_byte_reg <= lsg_pkg::LIMIT_RESET;
        end
        else if (reg_wr_i && reg_addr_i == lsg_pkg::UPPER_LOW_ADDR)
            upper_limit_low_byte_reg <= reg_wdata_i;
        else if (reg_wr_i && reg_addr_i == lsg_pkg::UPPER_HIGH_ADDR)
            upper_limit_high_byte_reg <= reg_wdata_i;
    end

    // low threshold bytes, independent of the high ones
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            lower_limit_low_byte_reg <= lsg_pkg::LIMIT_RESET;
            lower_limit_high_byte_reg <= lsg_pkg::LIMIT_RESET;
        end
        else if (reg_wr_i && reg_addr_i == lsg_pkg::LOWER_LOW_ADDR)
            lower_limit_low_byte_reg <= reg_wdata_i;
        else if (reg_wr_i && reg_addr_i == lsg_pkg::LOWER_HIGH_ADDR)
            lower_limit_high_byte_reg <= reg_wdata_i;
    end

    // measurement sequencer; a shutdown aborts a running measurement
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            state_reg <= lsg_pkg::SEQ_IDLE;
        else
        begin
            case (state_reg)
                lsg_pkg::SEQ_IDLE:
                    if (go)
                        state_reg <= lsg_pkg::SEQ_BUSY;
                lsg_pkg::SEQ_BUSY:
                    if (meas_done_i || !sensor_on)
                        state_reg <= lsg_pkg::SEQ_IDLE;
                default:
                    state_reg <= lsg_pkg::SEQ_IDLE;
            endcase
        end
    end

    // one start pulse per idle-to-busy step
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            meas_start_o <= 1'b0;
        else
            meas_start_o <= (state_reg == lsg_pkg::SEQ_IDLE) && go;
    end

    // only the ambient result feeds the window check
    lsg_window_eval u_window_eval (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .sample_valid_i(meas_valid),
        .sample_i(als_result_i),
        .upper_limit_i({upper_limit_high_byte_reg, upper_limit_low_byte_reg}),
        .lower_limit_i({lower_limit_high_byte_reg, lower_limit_low_byte_reg}),
        .enable_i(threshold_irq_enable),
        .persist_code_i(light_config_second_reg[lsg_pkg::PERS_MSB:lsg_pkg::PERS_LSB]),
        .raise_upper_o(raise_upper),
        .raise_lower_o(raise_lower)
    );

    // sticky flags, read clears, a set in the same cycle wins
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            upper_crossing_flag_reg <= 1'b0;
            lower_crossing_flag_reg <= 1'b0;
            force_done_flag_reg <= 1'b0;
        end
        else
        begin
            upper_crossing_flag_reg <= raise_upper | (upper_crossing_flag_reg & ~status_read);
            lower_crossing_flag_reg <= raise_lower | (lower_crossing_flag_reg & ~status_read);
            force_done_flag_reg <= (meas_valid & force_mode) | (force_done_flag_reg & ~status_read);
        end
    end

    // read mux; undefined codes read as zero
    always_comb
    begin
        read_mux = lsg_pkg::READ_IDLE;
        case (reg_addr_i)
            lsg_pkg::CONF_FIRST_ADDR: read_mux = light_config_first_reg;
            lsg_pkg::CONF_SECOND_ADDR: read_mux = light_config_second_reg;
            lsg_pkg::UPPER_LOW_ADDR: read_mux = upper_limit_low_byte_reg;
            lsg_pkg::UPPER_HIGH_ADDR: read_mux = upper_limit_high_byte_reg;
            lsg_pkg::LOWER_LOW_ADDR: read_mux = lower_limit_low_byte_reg;
            lsg_pkg::LOWER_HIGH_ADDR: read_mux = lower_limit_high_byte_reg;
            lsg_pkg::STATUS_ADDR:
            begin
                read_mux[lsg_pkg::UPPER_FLAG_BIT] = upper_crossing_flag_reg;
                read_mux[lsg_pkg::LOWER_FLAG_BIT] = lower_crossing_flag_reg;
                read_mux[lsg_pkg::FORCE_DONE_BIT] = force_done_flag_reg;
            end
            default: read_mux = lsg_pkg::READ_IDLE;
        endcase
    end

    // read data registered one cycle after the strobe, held until the next read
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
            reg_rdata_o <= lsg_pkg::READ_IDLE;
        else if (reg_rd_i)
            reg_rdata_o <= read_mux;
    end

    // one shared setting for both channels
    // diode area and gain straight from the register
    assign diode_area_select_o = light_config_second_reg[lsg_pkg::DIODE_BIT];
    assign light_gain_select_o = light_config_second_reg[lsg_pkg::GAIN_MSB:lsg_pkg::GAIN_LSB];
    assign integration_period_select_o = light_config_first_reg[lsg_pkg::INTEG_MSB:lsg_pkg::INTEG_LSB];
    assign sensor_on_o = sensor_on;
    // pin low while a crossing flag is pending
    assign alert_n_o = ~(upper_crossing_flag_reg | lower_crossing_flag_reg);

    selftimed_restart_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (meas_valid && sensor_on && !force_mode) ##1 (sensor_on && !force_mode) |=> meas_start_o)
        else $error("selftimed measurement did not restart");
    start_needs_trigger_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (meas_start_o && $past(force_mode)) |-> $past(trigger_pending))
        else $error("force mode started without trigger");
    one_per_trigger_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (meas_valid && force_mode && !reg_wr_i) |=> !trigger_pending ##1 !meas_start_o)
        else $error("trigger not consumed after its measurement");
    reset_selftimed_a: assert property (@(posedge clk_sys_i)
        reset_i |=> !force_mode && !threshold_irq_enable)
        else $error("reset left force mode or enable on");
    read_clears_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (status_read && !raise_upper && !raise_lower) |=> !upper_crossing_flag_reg && !lower_crossing_flag_reg)
        else $error("status read did not clear flags");
    set_beats_clear_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (status_read && raise_upper) |=> upper_crossing_flag_reg && !alert_n_o)
        else $error("crossing lost against status read");
    limit_write_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (reg_wr_i && reg_addr_i == lsg_pkg::UPPER_HIGH_ADDR) |=> upper_limit_high_byte_reg == $past(reg_wdata_i))
        else $error("high threshold byte not written");
    gain_follows_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (reg_wr_i && reg_addr_i == lsg_pkg::CONF_SECOND_ADDR)
        |=> light_gain_select_o == $past(reg_wdata_i[lsg_pkg::GAIN_MSB:lsg_pkg::GAIN_LSB]))
        else $error("gain output does not follow register");

    selftimed_run_c: cover property (@(posedge clk_sys_i) disable iff (reset_i)
        meas_start_o && !force_mode);
    forced_run_c: cover property (@(posedge clk_sys_i) disable iff (reset_i)
        meas_valid && force_mode);
    flag_read_c: cover property (@(posedge clk_sys_i) disable iff (reset_i)
        status_read && upper_crossing_flag_reg);

endmodule : lsg_light_sensor

// ---- logic/lsg_pkg.sv ----
// constants and types shared by the light sensor configuration and threshold logic
package lsg_pkg;

    // register command codes
    localparam logic [7:0] CONF_FIRST_ADDR = 8'h00;
    localparam logic [7:0] CONF_SECOND_ADDR = 8'h01;
    localparam logic [7:0] UPPER_LOW_ADDR = 8'h04;
    localparam logic [7:0] UPPER_HIGH_ADDR = 8'h05;
    localparam logic [7:0] LOWER_LOW_ADDR = 8'h06;
    localparam logic [7:0] LOWER_HIGH_ADDR = 8'h07;
    localparam logic [7:0] STATUS_ADDR = 8'h17;

    // reset values
    localparam logic [7:0] CONF_FIRST_RESET = 8'h01;
    localparam logic [7:0] CONF_SECOND_RESET = 8'h80;
    localparam logic [7:0] LIMIT_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // first configuration register fields
    localparam int SHUT_FIRST_BIT = 0;
    localparam int IRQ_EN_BIT = 1;
    localparam int TRIGGER_BIT = 2;
    localparam int FORCE_MODE_BIT = 3;
    localparam int INTEG_LSB = 4;
    localparam int INTEG_MSB = 6;

    // second configuration register fields
    localparam int PERS_LSB = 1;
    localparam int PERS_MSB = 2;
    localparam int GAIN_LSB = 3;
    localparam int GAIN_MSB = 4;
    localparam int DIODE_BIT = 6;
    localparam int SHUT_SECOND_BIT = 7;

    // status register fields
    localparam int UPPER_FLAG_BIT = 1;
    localparam int LOWER_FLAG_BIT = 2;
    localparam int FORCE_DONE_BIT = 3;

    // gain encodings: x1, x2, x0.66, x0.5
    localparam logic [1:0] GAIN_X1 = 2'h0;
    localparam logic [1:0] GAIN_X2 = 2'h1;
    localparam logic [1:0] GAIN_X066 = 2'h2;
    localparam logic [1:0] GAIN_X05 = 2'h3;

    // persistence encodings and the streak each one needs
    localparam logic [1:0] PERS_CODE_ONE = 2'h0;
    localparam logic [1:0] PERS_CODE_TWO = 2'h1;
    localparam logic [1:0] PERS_CODE_FOUR = 2'h2;
    localparam logic [1:0] PERS_CODE_EIGHT = 2'h3;
    localparam logic [3:0] STREAK_ONE = 4'h1;
    localparam logic [3:0] STREAK_TWO = 4'h2;
    localparam logic [3:0] STREAK_FOUR = 4'h4;
    localparam logic [3:0] STREAK_EIGHT = 4'h8;
    localparam logic [3:0] STREAK_ZERO = 4'h0;
    localparam logic [3:0] STREAK_STEP = 4'h1;

    // measurement sequencer states
    typedef enum logic [0:0] {SEQ_IDLE, SEQ_BUSY} lsg_seq_state_type;

endpackage : lsg_pkg

// ---- logic/lsg_window_eval.sv ----
// threshold window check with persistence streak and re-arm
`timescale 1ns/1ps
module lsg_window_eval (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic sample_valid_i,
    input wire logic [15:0] sample_i,
    input wire logic [15:0] upper_limit_i,
    input wire logic [15:0] lower_limit_i,
    input wire logic enable_i,
    input wire logic [1:0] persist_code_i,
    output logic raise_upper_o,
    output logic raise_lower_o
);

    logic [3:0] streak_reg;
    logic [3:0] streak_next;
    logic [3:0] target;
    logic fired_reg;
    logic above;
    logic below;
    logic outside;
    logic raise;

    // window compare on the ambient sample only
    assign above = sample_i > upper_limit_i;
    assign below = sample_i < lower_limit_i;
    assign outside = above | below;

    always_comb
    begin
        case (persist_code_i)
            lsg_pkg::PERS_CODE_ONE: target = lsg_pkg::STREAK_ONE;
            lsg_pkg::PERS_CODE_TWO: target = lsg_pkg::STREAK_TWO;
            lsg_pkg::PERS_CODE_FOUR: target = lsg_pkg::STREAK_FOUR;
            lsg_pkg::PERS_CODE_EIGHT: target = lsg_pkg::STREAK_EIGHT;
            default: target = lsg_pkg::STREAK_ONE;
        endcase
    end

    // streak grows outside, clears inside; saturates at eight
    always_comb
    begin
        if (!outside)
            streak_next = lsg_pkg::STREAK_ZERO;
        else if (streak_reg == lsg_pkg::STREAK_EIGHT)
            streak_next = lsg_pkg::STREAK_EIGHT;
        else
            streak_next = streak_reg + lsg_pkg::STREAK_STEP;
    end

    // no re-raise until the sample comes back inside
    assign raise = sample_valid_i & enable_i & outside & ~fired_reg & (streak_next >= target);

    // streak counter, idles at zero while the function is off
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i || !enable_i)
            streak_reg <= lsg_pkg::STREAK_ZERO;
        else if (sample_valid_i)
            streak_reg <= streak_next;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i || !enable_i)
            fired_reg <= 1'b0;
        else if (raise)
            fired_reg <= 1'b1;
        else if (sample_valid_i && !outside)
            fired_reg <= 1'b0;
    end

    // registered one-cycle raise pulses, side taken from the sample
    always_ff @(posedge clk_sys_i)
    begin
        if (reset_i)
        begin
            raise_upper_o <= 1'b0;
            raise_lower_o <= 1'b0;
        end
        else
        begin
            raise_upper_o <= raise & above;
            raise_lower_o <= raise & below;
        end
    end

    raise_needs_sample_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (raise_upper_o || raise_lower_o) |-> $past(sample_valid_i && enable_i))
        else $error("raise without an enabled sample");
    no_rearm_raise_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (sample_valid_i && fired_reg && outside) |=> !(raise_upper_o || raise_lower_o))
        else $error("raise repeated without leaving the threshold");
    inside_clears_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (sample_valid_i && enable_i && !outside) |=> (streak_reg == lsg_pkg::STREAK_ZERO) && !fired_reg)
        else $error("inside sample did not clear streak");
    single_hit_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (sample_valid_i && enable_i && persist_code_i == lsg_pkg::PERS_CODE_ONE && above && !fired_reg)
        |=> raise_upper_o)
        else $error("persistence one did not raise at once");
    eight_needed_a: assert property (@(posedge clk_sys_i) disable iff (reset_i)
        (sample_valid_i && persist_code_i == lsg_pkg::PERS_CODE_EIGHT
        && streak_reg < (lsg_pkg::STREAK_EIGHT - lsg_pkg::STREAK_STEP)) |=> !raise_upper_o && !raise_lower_o)
        else $error("persistence eight raised early");

    upper_raise_c: cover property (@(posedge clk_sys_i) disable iff (reset_i) raise_upper_o);
    lower_raise_c: cover property (@(posedge clk_sys_i) disable iff (reset_i) raise_lower_o);

endmodule : lsg_window_eval

// ---- tb/lsg_front_end_model.sv ----
// behavioural analog front end answering each start pulse with one result
`timescale 1ns/1ps
module lsg_front_end_model (
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic meas_start_i,
    input wire logic [7:0] delay_i,
    input wire logic [15:0] value_i,
    output logic meas_done_o,
    output logic [15:0] als_result_o
);
    logic [7:0] cnt_reg;

    // one result per start
    // result toggles outside the done cycle so stale data never looks valid
    always_ff @(posedge clk_sys_i)
    begin
        meas_done_o <= 1'b0;
        als_result_o <= ~als_result_o;
        if (reset_i)
        begin
            cnt_reg <= 8'h00;
            als_result_o <= 16'h5a5a;
        end
        else if (meas_start_i)
        begin
            cnt_reg <= delay_i;
        end
        else if (cnt_reg == 8'h01)
        begin
            cnt_reg <= 8'h00;
            meas_done_o <= 1'b1;
            als_result_o <= value_i;
        end
        else if (cnt_reg > 8'h01)
        begin
            cnt_reg <= cnt_reg - 8'h01;
        end
    end
endmodule : lsg_front_end_model

// ---- tb/light_sensor_gain_threshold_irq_tb.sv ----
// self-checking bench for the light sensor configuration and threshold logic
`timescale 1ns/1ps
module light_sensor_gain_threshold_irq_tb;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata, rd_val, b;
    logic meas_start, meas_done, sensor_on, diode, alert_n;
    logic [15:0] als_result, up, lo, v;
    logic [15:0] res_value = 16'h0000;
    logic [7:0] fe_delay = 8'h04;
    logic [31:0] lim;
    logic [2:0] integ;
    logic [1:0] gain;
    int err_count = 0;
    int num_checks = 0;
    int start_cnt = 0;
    int done_cnt = 0;
    int cyc = 0;
    int last_done = 0;
    int n;
    bit gap_chk = 0;

    // 50 ns system clock
    always #25 clk_sys_i = ~clk_sys_i;

    lsg_light_sensor DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .reg_addr_i(reg_addr),
        .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
        .meas_start_o(meas_start), .meas_done_i(meas_done), .als_result_i(als_result),
        .sensor_on_o(sensor_on), .integration_period_select_o(integ), .light_gain_select_o(gain),
        .diode_area_select_o(diode), .alert_n_o(alert_n));

    lsg_front_end_model u_front_end (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .meas_start_i(meas_start),
        .delay_i(fe_delay), .value_i(res_value), .meas_done_o(meas_done), .als_result_o(als_result));

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic final_report();
        if (err_count == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : final_report

    task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr <= 1'b0;
    endtask : reg_write

    // read data lands one cycle after the strobe edge
    task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk_sys_i);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd <= 1'b0;
        #1;
        rd_val = reg_rdata;
        check(what, {8'h00, rd_val}, {8'h00, exp});
    endtask : rd_chk

    // bounded wait for a number of completed measurements
    task automatic wait_dones(input int k);
        int target;
        target = done_cnt + k;
        for (int i = 0; i < 2000 && done_cnt < target; i++)
            @(posedge clk_sys_i);
        if (done_cnt < target)
        begin
            err_count++;
            final_report();
        end
    endtask : wait_dones

    // consecutive outside results needed per persistence code
    function automatic logic [15:0] streak(input int p);
        return 16'h0001 << p;
    endfunction : streak

    // tally starts and completions; selftimed restarts follow a done by two cycles
    always @(posedge clk_sys_i)
    begin
        cyc <= cyc + 1;
        if (meas_done)
        begin
            done_cnt <= done_cnt + 1;
            last_done <= cyc;
        end
        if (meas_start)
        begin
            start_cnt <= start_cnt + 1;
            if (gap_chk)
                check("restart gap", 16'(cyc - last_done), 16'h0002);
        end
    end

    // hang guard well past the longest sequence
    initial
    begin
        #4ms;
        err_count++;
        final_report();
    end

    initial
    begin
        void'($urandom(32'h5615c9e0));
        repeat (3) @(posedge clk_sys_i);
        reset_i <= 1'b0;
        rd_chk("conf first", 8'h00, 8'h01);
        rd_chk("conf second", 8'h01, 8'h80);
        for (int a = 4; a < 8; a++)
            rd_chk("limit reset", 8'(a), 8'h00);
        rd_chk("status reset", 8'h17, 8'h00);
        rd_chk("unmapped", 8'h02, 8'h00);
        check("alert idle", {15'h0, alert_n}, 16'h0001);
        // every gain code with both diode areas, one setting for both channels
        for (int i = 0; i < 8; i++)
        begin
            b = {1'b1, i[2], 1'b0, i[1:0], 3'b000};
            reg_write(8'h01, b);
            rd_chk("conf second rb", 8'h01, b);
            check("gain", {14'h0, gain}, {14'h0, b[4:3]});
            check("diode", {15'h0, diode}, {15'h0, b[6]});
        end
        up = 16'h1000 + 16'($urandom_range(16'hd000));
        lo = 16'h0100 + 16'($urandom_range(16'h0800));
        lim = {lo, up};
        for (int a = 4; a < 8; a++)
            reg_write(8'(a), lim[(a - 4) * 8 +: 8]);
        for (int a = 4; a < 8; a++)
            rd_chk("limit rb", 8'(a), lim[(a - 4) * 8 +: 8]);
        // switch on: both config bytes, lowest gain, half diode, no shortest integration
        fe_delay <= 8'(4 + $urandom_range(6));
        res_value <= lo + 16'h0001;
        reg_write(8'h00, 8'h12);
        reg_write(8'h01, 8'h58);
        // let the write edge settle before looking at the derived level
        #1;
        check("sensor on", {15'h0, sensor_on}, 16'h0001);
        check("integration", {13'h0, integ}, 16'h0001);
        wait_dones(2);
        gap_chk = 1;
        for (int p = 0; p < 4; p++)
        begin
            reg_write(8'h01, 8'(p << 1));
            res_value <= lo + 16'($urandom_range(up - lo));
            wait_dones(2);
            v = up + 16'h0001 + 16'($urandom_range(255));
            res_value <= v;
            n = done_cnt;
            for (int i = 0; i < 2000 && alert_n !== 1'b0; i++)
                @(posedge clk_sys_i);
            // a streak that never raises is a hang, not a pass
            if (alert_n !== 1'b0)
            begin
                err_count++;
                final_report();
            end
            check("streak", 16'(done_cnt - n), streak(p));
            rd_chk("upper flag", 8'h17, 8'h02);
            wait_dones(3);
            check("no rearm", {15'h0, alert_n}, 16'h0001);
            rd_chk("no rearm flag", 8'h17, 8'h00);
        end
        reg_write(8'h01, 8'h00);
        res_value <= lo;
        wait_dones(2);
        res_value <= lo - 16'h0001 - 16'($urandom_range(255));
        wait_dones(1);
        repeat (3) @(posedge clk_sys_i);
        check("lower alert", {15'h0, alert_n}, 16'h0000);
        rd_chk("lower flag", 8'h17, 8'h04);
        // interrupt function off: outside results raise nothing
        reg_write(8'h00, 8'h10);
        res_value <= up + 16'h0001;
        wait_dones(3);
        check("disabled alert", {15'h0, alert_n}, 16'h0001);
        rd_chk("disabled flag", 8'h17, 8'h00);
        // active force mode: idle until triggered, then exactly one measurement
        gap_chk = 0;
        reg_write(8'h00, 8'h18);
        repeat (30) @(posedge clk_sys_i);
        n = start_cnt;
        repeat (30) @(posedge clk_sys_i);
        check("force idle", 16'(start_cnt - n), 16'h0000);
        for (int k = 0; k < 2; k++)
        begin
            fe_delay <= 8'(4 + $urandom_range(6));
            n = start_cnt;
            reg_write(8'h00, 8'h1c);
            repeat (40) @(posedge clk_sys_i);
            check("one start", 16'(start_cnt - n), 16'h0001);
            rd_chk("trigger clear", 8'h00, 8'h18);
            rd_chk("force done", 8'h17, 8'h08);
        end
        final_report();
    end
endmodule : light_sensor_gain_threshold_irq_tb
